// ### design/mic_pkg.sv
// Package for the microcontroller interrupt controller.
// Assumes one core clock; register port addresses are file addresses of the core.
package mic_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [8:0] MIC_ADDR_IRQ_CONTROL = 9'h00B;
  localparam logic [8:0] MIC_ADDR_FLAG_A      = 9'h00C;
  localparam logic [8:0] MIC_ADDR_FLAG_B      = 9'h00D;
  localparam logic [8:0] MIC_ADDR_ENABLE_A    = 9'h08C;
  localparam logic [8:0] MIC_ADDR_ENABLE_B    = 9'h08D;
  localparam logic [8:0] MIC_ADDR_OPTION      = 9'h081;
  localparam logic [8:0] MIC_ADDR_PORT_B      = 9'h006;
  localparam logic [8:0] MIC_ADDR_PORT_EN     = 9'h090;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MIC_BIT_GIE   = 7;
  localparam int MIC_BIT_PEIE  = 6;
  localparam int MIC_BIT_TIMER_ZERO_ENABLE  = 5;
  localparam int MIC_BIT_EXTE  = 4;
  localparam int MIC_BIT_PORT_CHANGE_ENABLE  = 3;
  localparam int MIC_BIT_TIMER_ZERO_FLAG  = 2;
  localparam int MIC_BIT_EXTF  = 1;
  localparam int MIC_BIT_PORT_CHANGE_FLAG  = 0;
  localparam int MIC_BIT_EDGE  = 6;

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  MIC_RST_OPTION  = 8'hFF;
  localparam logic [7:0]  MIC_RST_ZERO    = 8'h00;
  localparam logic [12:0] MIC_VECTOR      = 13'h0004;
  localparam logic [1:0]  MIC_QPHASE_LAST = 2'h3;
  localparam logic [7:0]  MIC_TMR_FULL    = 8'hFF;
  localparam int          MIC_OST_TOSC    = 1024;
  localparam int          MIC_CORE_MHZ    = 250;
  localparam int          MIC_OSC_MHZ     = 24;
  localparam int          MIC_OST_CYCLES  = (MIC_OST_TOSC * MIC_CORE_MHZ + MIC_OSC_MHZ - 1)
                                            / MIC_OSC_MHZ;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mic_reg_req_s;

  typedef struct packed {
    logic        take;
    logic        ret;
    logic        sleep;
    logic [12:0] pc;
  } mic_core_req_s;

  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_SLEEP,
    MIC_OST
  } mic_pwr_e;

endpackage : mic_pkg

// ### design/mic_edge_sync.sv
// Two-flop synchroniser with edge flags for the interrupt pins.
// Assumes pins are asynchronous to core_clk_in.
`timescale 1ns/1ps
module mic_edge_sync
  import mic_pkg::*;
#(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  // Pins
  input  wire logic [WIDTH-1:0] pins_in,
  // Synchronised level and change
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;
  assign fall_out  = ~sync_ff & prev_ff;

endmodule : mic_edge_sync

// ### design/mic_irq_ctrl.sv
// Interrupt controller for an 8-bit microcontroller core.
// Assumes core fetch/execute strobes and register port on core_clk_in.
//
// Overview of operation
// - Flags set on their event regardless of individual and global enables.
// - Global enable bit 7 blocks all; when set, enabled flagged source vectors.
// - Reset clears the global enable.
// - Return-from-isr pops the return address and sets the global enable.
// - On accept: clear global enable, push return address, load PC 0004h.
// - Peripheral flags/enables in two register pairs, gated by group enable.
// - Pin-edge and port-change latency three or four instruction cycles.
// - Pin edge polarity from option bit 6; valid edge sets flag bit 1.
// - Pin edge enable bit 4; wakes core if set; global enable decides vector.
// - Timer-zero rollover FFh to 00h sets bit 2; enable bit 5.
// - Upper port-B change sets bit 0; its enable moved to bit 3.
// - A change coinciding with a port read may be missed.
// - Only the program counter is saved on entry.
// - Crystal-mode wake waits 1024 oscillator periods; none in external clock.
// - Wake with global enable clear continues in line.
// - Enabled source wakes the core regardless of global enable.
// - Pending enabled interrupt makes sleep a no-operation.
`timescale 1ns/1ps
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int PERIPH_W   = 8,
  parameter int OST_CYCLES = MIC_OST_CYCLES
) (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  // Register port
  input  wire mic_reg_req_s        reg_req_in,
  output logic [7:0]               reg_rdata_out,
  // Core instruction flow
  input  wire logic                q_end_in,
  input  wire logic                return_from_isr_in,
  input  wire logic                sleep_in,
  input  wire logic [12:0]         ret_addr_in,
  input  wire logic [12:0]         stack_top_in,
  output mic_core_req_s            core_out,
  output logic [12:0]              push_addr_out,
  output logic                     push_out,
  output logic                     pop_out,
  output logic                     asleep_out,
  output logic                     irq_req_out,
  // Sources
  input  wire logic                ext_irq_pin_in,
  input  wire logic [7:4]          port_b_pins_in,
  input  wire logic [7:0]          timer_zero_count_in,
  input  wire logic                timer_zero_tick_in,
  input  wire logic [PERIPH_W-1:0] periph_set_a_in,
  input  wire logic [PERIPH_W-1:0] periph_set_b_in,
  input  wire logic                ext_clock_mode_in
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]          irq_control_reg_ff;
  logic [PERIPH_W-1:0] periph_flag_reg_a_ff;
  logic [PERIPH_W-1:0] periph_flag_reg_b_ff;
  logic [PERIPH_W-1:0] periph_enable_reg_a_ff;
  logic [PERIPH_W-1:0] periph_enable_reg_b_ff;
  logic [7:0]          option_control_ff;
  logic [7:4]          port_latch_ff;
  logic [7:0]          rdata_ff;
  logic                pend_ff;
  logic                irq_req_ff;
  logic                take_ff;
  logic                pop_ff;
  logic                asleep_ff;
  logic [12:0]         pc_ff;
  logic [12:0]         push_addr_ff;
  mic_pwr_e            pwr_ff;
  logic [15:0]         ost_cnt_ff;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  mic_edge_sync #(
    .WIDTH (5)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .pins_in     ({port_b_pins_in, ext_irq_pin_in}),
    .level_out   (pin_lvl),
    .rise_out    (pin_rise),
    .fall_out    (pin_fall)
  );

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  wire edge_polarity_select = option_control_ff[MIC_BIT_EDGE];
  wire ext_event  = edge_polarity_select ? pin_rise[0] : pin_fall[0];
  wire port_read  = reg_req_in.rd && (reg_req_in.addr == MIC_ADDR_PORT_B);
  wire port_event = (pin_lvl[4:1] != port_latch_ff);
  wire tmr_event  = timer_zero_tick_in && (timer_zero_count_in == MIC_TMR_FULL);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_ctl  = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_IRQ_CONTROL);
  wire wr_fa   = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_FLAG_A);
  wire wr_fb   = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_FLAG_B);
  wire wr_ea   = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_ENABLE_A);
  wire wr_eb   = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_ENABLE_B);
  wire wr_opt  = reg_req_in.wr && (reg_req_in.addr == MIC_ADDR_OPTION);

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = MIC_RST_ZERO;
    unique case (reg_req_in.addr)
      MIC_ADDR_IRQ_CONTROL: rd_mux = irq_control_reg_ff;
      MIC_ADDR_FLAG_A:      rd_mux = 8'(periph_flag_reg_a_ff);
      MIC_ADDR_FLAG_B:      rd_mux = 8'(periph_flag_reg_b_ff);
      MIC_ADDR_ENABLE_A:    rd_mux = 8'(periph_enable_reg_a_ff);
      MIC_ADDR_ENABLE_B:    rd_mux = 8'(periph_enable_reg_b_ff);
      MIC_ADDR_OPTION:      rd_mux = option_control_ff;
      MIC_ADDR_PORT_B:      rd_mux = {pin_lvl[4:1], 4'h0};
      default:              rd_mux = MIC_RST_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // Flag and enable next values; hardware set wins over write
  // ---------------------------------------------------------------
  logic [7:0] ctl_base;
  logic [7:0] nxt_ctl;
  assign ctl_base = wr_ctl ? reg_req_in.wdata : irq_control_reg_ff;

  wire take_now = irq_req_ff && q_end_in && (pwr_ff == MIC_RUN);
  wire ret_now  = return_from_isr_in && q_end_in;

  always_comb begin
    nxt_ctl = ctl_base;
    if (ext_event) nxt_ctl[MIC_BIT_EXTF] = 1'b1;
    if (tmr_event) nxt_ctl[MIC_BIT_TIMER_ZERO_FLAG] = 1'b1;
    if (port_event && !port_read) nxt_ctl[MIC_BIT_PORT_CHANGE_FLAG] = 1'b1;
    if (ret_now)  nxt_ctl[MIC_BIT_GIE] = 1'b1;
    if (take_now) nxt_ctl[MIC_BIT_GIE] = 1'b0;
  end

  wire [PERIPH_W-1:0] nxt_fa = (wr_fa ? PERIPH_W'(reg_req_in.wdata) : periph_flag_reg_a_ff)
                               | periph_set_a_in;
  wire [PERIPH_W-1:0] nxt_fb = (wr_fb ? PERIPH_W'(reg_req_in.wdata) : periph_flag_reg_b_ff)
                               | periph_set_b_in;

  // ---------------------------------------------------------------
  // Request qualification
  // ---------------------------------------------------------------
  wire periph_any = |(periph_flag_reg_a_ff & periph_enable_reg_a_ff)
                  | |(periph_flag_reg_b_ff & periph_enable_reg_b_ff);
  wire core_any = (irq_control_reg_ff[MIC_BIT_EXTF] & irq_control_reg_ff[MIC_BIT_EXTE])
                | (irq_control_reg_ff[MIC_BIT_TIMER_ZERO_FLAG] & irq_control_reg_ff[MIC_BIT_TIMER_ZERO_ENABLE])
                | (irq_control_reg_ff[MIC_BIT_PORT_CHANGE_FLAG] & irq_control_reg_ff[MIC_BIT_PORT_CHANGE_ENABLE]);
  wire pend_any = core_any | (irq_control_reg_ff[MIC_BIT_PEIE] & periph_any);
  wire req_any  = irq_control_reg_ff[MIC_BIT_GIE] & pend_any;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_control_reg_ff     <= MIC_RST_ZERO;
      periph_flag_reg_a_ff   <= '0;
      periph_flag_reg_b_ff   <= '0;
      periph_enable_reg_a_ff <= '0;
      periph_enable_reg_b_ff <= '0;
      option_control_ff      <= MIC_RST_OPTION;
      rdata_ff               <= MIC_RST_ZERO;
    end else begin
      irq_control_reg_ff   <= nxt_ctl;
      periph_flag_reg_a_ff <= nxt_fa;
      periph_flag_reg_b_ff <= nxt_fb;
      if (wr_ea) periph_enable_reg_a_ff <= PERIPH_W'(reg_req_in.wdata);
      if (wr_eb) periph_enable_reg_b_ff <= PERIPH_W'(reg_req_in.wdata);
      if (wr_opt) option_control_ff <= reg_req_in.wdata;
      rdata_ff <= reg_req_in.rd ? rd_mux : MIC_RST_ZERO;
    end
  end

  // Port-change reference follows the pins when read
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      port_latch_ff <= 4'h0;
    end else if (port_read) begin
      port_latch_ff <= pin_lvl[4:1];
    end
  end

  // ---------------------------------------------------------------
  // Instruction-cycle sampling and vectoring
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pend_ff      <= 1'b0;
      irq_req_ff   <= 1'b0;
      take_ff      <= 1'b0;
      pop_ff       <= 1'b0;
      pc_ff        <= '0;
      push_addr_ff <= '0;
    end else begin
      take_ff <= take_now;
      pop_ff  <= ret_now;
      if (q_end_in) begin
        pend_ff    <= pend_any;
        irq_req_ff <= req_any;
      end
      if (take_now) begin
        irq_req_ff   <= 1'b0;
        push_addr_ff <= ret_addr_in;
        pc_ff        <= MIC_VECTOR;
      end else if (ret_now) begin
        pc_ff <= stack_top_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sleep and oscillator start-up
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pwr_ff     <= MIC_RUN;
      ost_cnt_ff <= '0;
      asleep_ff  <= 1'b0;
    end else begin
      unique case (pwr_ff)
        MIC_RUN: begin
          if (sleep_in && q_end_in && !pend_any) begin
            pwr_ff    <= MIC_SLEEP;
            asleep_ff <= 1'b1;
          end
        end
        MIC_SLEEP: begin
          if (pend_any) begin
            if (ext_clock_mode_in) begin
              pwr_ff    <= MIC_RUN;
              asleep_ff <= 1'b0;
            end else begin
              pwr_ff     <= MIC_OST;
              ost_cnt_ff <= 16'(OST_CYCLES - 1);
            end
          end
        end
        MIC_OST: begin
          if (ost_cnt_ff == '0) begin
            pwr_ff    <= MIC_RUN;
            asleep_ff <= 1'b0;
          end else begin
            ost_cnt_ff <= ost_cnt_ff - 16'h0001;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out = rdata_ff;
  assign core_out      = '{take: take_ff, ret: pop_ff, sleep: asleep_ff, pc: pc_ff};
  assign push_addr_out = push_addr_ff;
  assign push_out      = take_ff;
  assign pop_out       = pop_ff;
  assign asleep_out    = asleep_ff;
  assign irq_req_out   = irq_req_ff;

endmodule : mic_irq_ctrl

// ### bench/mic_irq_ctrl_asserts.sv
// Port checker for the interrupt controller.
// Assumes q_end_in pulses at most once every four clocks.
`timescale 1ns/1ps
module mic_irq_ctrl_asserts
  import mic_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk_in,
  input wire logic          reset_in,
  // Watched ports
  input wire mic_reg_req_s  reg_req_in,
  input wire logic [7:0]    reg_rdata_out,
  input wire logic          q_end_in,
  input wire logic          return_from_isr_in,
  input wire mic_core_req_s core_out,
  input wire logic          push_out,
  input wire logic          pop_out,
  input wire logic          asleep_out,
  input wire logic          irq_req_out
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  reset_quiet_a: assert property (disable iff (1'b0) reset_in |=> !push_out && !irq_req_out)
    else $error("outputs active after reset");
  take_at_qend_a: assert property (push_out |-> $past(q_end_in) && $past(irq_req_out))
    else $error("take without sampled request");
  take_vector_a: assert property (push_out |-> ##[0:1] core_out.pc == MIC_VECTOR)
    else $error("vector not loaded on take");
  take_drops_req_a: assert property (push_out |-> ##[1:5] !irq_req_out)
    else $error("request stays after take");
  take_single_a: assert property (push_out |=> !push_out)
    else $error("take longer than one cycle");
  pop_on_ret_a: assert property (pop_out |-> $past(return_from_isr_in && q_end_in))
    else $error("pop without return");
  no_take_asleep_a: assert property (asleep_out && $past(asleep_out) |-> !push_out)
    else $error("take while asleep");
  req_at_qend_a: assert property ($rose(irq_req_out) |-> $past(q_end_in))
    else $error("request changed off sample point");
  rdata_idle_a: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");

  cover property (push_out);
  cover property (pop_out);
  cover property ($fell(asleep_out));
endmodule : mic_irq_ctrl_asserts

bind mic_irq_ctrl mic_irq_ctrl_asserts u_mic_irq_ctrl_asserts (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .q_end_in(q_end_in), .return_from_isr_in(return_from_isr_in),
  .core_out(core_out), .push_out(push_out), .pop_out(pop_out),
  .asleep_out(asleep_out), .irq_req_out(irq_req_out)
);

// ### bench/mic_core_model.sv
// Core model: instruction phases, return and sleep, call stack.
// Assumes push and pop arrive as one-cycle pulses.
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  // Clock, reset and commands
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ret_cmd_in,
  input  wire logic        sleep_cmd_in,
  // Controller side
  input  wire logic        asleep_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic [12:0] push_addr_in,
  output logic             q_end_out,
  output logic             return_from_isr_out,
  output logic             sleep_out,
  output logic [12:0]      ret_addr_out,
  output logic [12:0]      stack_top_out
);
  logic [1:0]  phase_ff;
  logic [12:0] pc_ff;
  logic [2:0]  sp_ff;
  logic        ret_ff;
  logic        slp_ff;
  logic [12:0] stack_ff [8];

  // No phases while the core sleeps
  assign q_end_out     = (phase_ff == MIC_QPHASE_LAST) && !asleep_in;
  assign return_from_isr_out    = q_end_out && ret_ff;
  assign sleep_out     = q_end_out && slp_ff;
  assign ret_addr_out  = pc_ff;
  assign stack_top_out = stack_ff[sp_ff - 3'h1];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      phase_ff <= 2'h0;
      pc_ff    <= 13'h0;
      sp_ff    <= 3'h0;
      ret_ff   <= 1'b0;
      slp_ff   <= 1'b0;
    end else begin
      if (!asleep_in) phase_ff <= phase_ff + 2'h1;
      if (q_end_out) pc_ff <= pc_ff + 13'h1;
      if (ret_cmd_in) ret_ff <= 1'b1;
      else if (q_end_out) ret_ff <= 1'b0;
      if (sleep_cmd_in) slp_ff <= 1'b1;
      else if (q_end_out) slp_ff <= 1'b0;
      // Only the return address is kept
      if (push_in) begin
        stack_ff[sp_ff] <= push_addr_in;
        sp_ff           <= sp_ff + 3'h1;
      end else if (pop_in) begin
        sp_ff <= sp_ff - 3'h1;
      end
    end
  end
endmodule : mic_core_model

// ### bench/tb_mic_irq_ctrl.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model and the bound port checker.
`timescale 1ns/1ps
module tb_mic_irq_ctrl
  import mic_pkg::*;
;
  typedef struct packed {
    logic [8:0] a;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
  } mic_row_s;
  logic          clk, rst, qe, rf, sl, push, pop, asleep, irq, pin, tick, emode, rcmd, scmd;
  logic [3:0]    pb;
  logic [7:0]    rdata, tcnt, pa, pbs;
  logic [12:0]   raddr, stop, paddr;
  mic_reg_req_s  req;
  mic_core_req_s core;
  mic_row_s      rows [6];
  int            fail_count, n_tests, n;

  mic_irq_ctrl #(.OST_CYCLES(8)) u_mic_irq_ctrl (.core_clk_in(clk), .reset_in(rst),
    .reg_req_in(req), .reg_rdata_out(rdata), .q_end_in(qe), .return_from_isr_in(rf), .sleep_in(sl),
    .ret_addr_in(raddr), .stack_top_in(stop), .core_out(core), .push_addr_out(paddr),
    .push_out(push), .pop_out(pop), .asleep_out(asleep), .irq_req_out(irq),
    .ext_irq_pin_in(pin), .port_b_pins_in(pb), .timer_zero_count_in(tcnt),
    .timer_zero_tick_in(tick), .periph_set_a_in(pa), .periph_set_b_in(pbs),
    .ext_clock_mode_in(emode));
  mic_core_model u_mic_core_model (.core_clk_in(clk), .reset_in(rst), .ret_cmd_in(rcmd),
    .sleep_cmd_in(scmd), .asleep_in(asleep), .push_in(push), .pop_in(pop),
    .push_addr_in(paddr), .q_end_out(qe), .return_from_isr_out(rf), .sleep_out(sl),
    .ret_addr_out(raddr), .stack_top_out(stop));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd

  // Bounded wait: 0 take, 1 pop, 2 wake
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic s;
    cnt = 0;
    s = 1'b0;
    while (!s) begin
      @(posedge clk);
      #1 cnt++;
      case (sel)
        0: s = (push === 1'b1);
        1: s = (pop === 1'b1);
        default: s = (asleep === 1'b0);
      endcase
      if (!s && cnt >= lim) begin
        check(16'h0, 16'h1);
        end_of_test();
      end
    end
  endtask : wait_for

  task automatic cmd(input logic is_sleep);
    @(posedge clk);
    if (is_sleep) scmd <= 1'b1;
    else rcmd <= 1'b1;
    @(posedge clk);
    scmd <= 1'b0;
    rcmd <= 1'b0;
  endtask : cmd

  task automatic tmr(input logic [7:0] c, input logic [7:0] e);
    @(posedge clk);
    tcnt <= c;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    rd(MIC_ADDR_IRQ_CONTROL, e);
  endtask : tmr

  initial begin
    {rst, pin, tick, emode, rcmd, scmd} = 6'b100000;
    {pb, tcnt, pa, pbs} = '0;
    req = '0;
    fail_count = 0;
    n_tests = 0;
    rows[0] = {MIC_ADDR_OPTION, 1'b0, 8'h00, 8'hFF};
    rows[1] = {MIC_ADDR_IRQ_CONTROL, 1'b0, 8'h00, 8'h00};
    rows[2] = {MIC_ADDR_ENABLE_A, 1'b1, 8'hA5, 8'hA5};
    rows[3] = {MIC_ADDR_ENABLE_B, 1'b1, 8'h5A, 8'h5A};
    rows[4] = {9'h1FF, 1'b1, 8'h33, 8'h00};
    rows[5] = {MIC_ADDR_ENABLE_A, 1'b1, 8'h00, 8'h00};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Rising pin edge, taken and vectored
    wr(MIC_ADDR_IRQ_CONTROL, 8'h90);
    @(posedge clk) pin <= 1'b1;
    wait_for(0, 24, n);
    check({15'h0, n <= 20}, 16'h1);
    @(posedge clk) #1 check({3'h0, core.pc}, {3'h0, MIC_VECTOR});
    rd(MIC_ADDR_IRQ_CONTROL, 8'h12);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h10);
    cmd(1'b0);
    wait_for(1, 12, n);
    rd(MIC_ADDR_IRQ_CONTROL, 8'h90);
    // Falling edge, timer rollover and port change with everything masked
    wr(MIC_ADDR_IRQ_CONTROL, 8'h00);
    rd(MIC_ADDR_IRQ_CONTROL, 8'h00);
    wr(MIC_ADDR_OPTION, 8'hBF);
    @(posedge clk) pin <= 1'b0;
    repeat (20) @(posedge clk);
    rd(MIC_ADDR_IRQ_CONTROL, 8'h02);
    check(irq, 1'b0);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h00);
    tmr(8'hFE, 8'h00);
    tmr(8'hFF, 8'h04);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h00);
    @(posedge clk) pb <= 4'h2;
    repeat (8) @(posedge clk);
    rd(MIC_ADDR_IRQ_CONTROL, 8'h01);
    // Peripheral sources behind the group enable
    wr(MIC_ADDR_IRQ_CONTROL, 8'h00);
    @(posedge clk) {pa, pbs} <= 16'h0801;
    @(posedge clk) {pa, pbs} <= 16'h0000;
    rd(MIC_ADDR_FLAG_A, 8'h08);
    rd(MIC_ADDR_FLAG_B, 8'h01);
    wr(MIC_ADDR_ENABLE_A, 8'h08);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h80);
    repeat (12) @(posedge clk);
    #1 check(irq, 1'b0);
    wr(MIC_ADDR_IRQ_CONTROL, 8'hC0);
    wait_for(0, 16, n);
    wr(MIC_ADDR_ENABLE_A, 8'h00);
    // Sleep with a pending source, then real sleeps
    wr(MIC_ADDR_OPTION, 8'hFF);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h12);
    cmd(1'b1);
    repeat (8) @(posedge clk);
    #1 check(asleep, 1'b0);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h10);
    cmd(1'b1);
    repeat (8) @(posedge clk);
    #1 check(asleep, 1'b1);
    @(posedge clk) pin <= 1'b1;
    wait_for(2, 40, n);
    check({15'h0, n >= 8}, 16'h1);
    repeat (16) @(posedge clk);
    #1 check(irq, 1'b0);
    rd(MIC_ADDR_PORT_B, 8'h20);
    wr(MIC_ADDR_IRQ_CONTROL, 8'h08);
    @(posedge clk) emode <= 1'b1;
    cmd(1'b1);
    repeat (8) @(posedge clk);
    #1 check(asleep, 1'b1);
    @(posedge clk) pb <= 4'h0;
    wait_for(2, 40, n);
    check({15'h0, n < 8}, 16'h1);
    // Reset in mid-run drops the global enable
    wr(MIC_ADDR_IRQ_CONTROL, 8'h80);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(MIC_ADDR_IRQ_CONTROL, 8'h00);
    end_of_test();
  end
endmodule : tb_mic_irq_ctrl
